// *** rtl/cutoff_pkg.sv ***
// constants, field layout and register map of the torque cutoff timer
// assumes a 40 MHz clock and a 32-bit APB register bus
package cutoff_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SEL     = 8'h04;
  localparam logic [7:0] OFS_RESTART = 8'h08;
  localparam logic [7:0] OFS_STAND   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_CLEAR   = 8'h14;

  // control register fields
  localparam int CTRL_ACK_MANUAL = 0;
  localparam int CTRL_BRAKE_LSB  = 1;
  localparam int CTRL_EVENT_LSB  = 3;
  localparam int CTRL_DIAG1      = 5;
  localparam int CTRL_DIAG2      = 6;
  localparam int CTRL_ENCODER    = 7;
  localparam int CTRL_WIDTH      = 8;

  // selection register fields, 3 bits each
  localparam int SEL_PRIMARY_LSB   = 0;
  localparam int SEL_SECONDARY_LSB = 4;
  localparam int SEL_ACK_LSB       = 8;
  localparam int SEL_RAMPED_LSB    = 12;

  // input selection codes
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_DUAL = 3'h5;

  localparam logic [1:0] BRAKE_NONE  = 2'h0;
  localparam logic [1:0] EVENT_FAULT = 2'h3;

  // reset values: auto ack, no brake, warning event, both diag pulses on
  localparam logic [7:0]  CTRL_RST    = 8'h68;
  localparam logic [15:0] SEL_RST     = 16'h0005;
  localparam logic [15:0] RESTART_RST = 16'h07d0;
  localparam logic [15:0] STAND_RST   = 16'h07d0;

  // timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_TIME_NS   = 1000000;
  localparam int TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int FILTER_TIME_NS = 2000;
  localparam int FILTER_INT     = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] FILTER_CYC      = 8'(FILTER_INT);
  localparam logic [7:0] DIAG_TIMEOUT_MS = 8'h14;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_COAST = 2'b01,
    ST_STILL = 2'b11
  } cutoff_state_t;

  // selected level out of the four input levels; dual means either channel
  function automatic logic sel_level(input logic [2:0] sel, input logic [3:0] lvl);
    logic r;
    r = 1'b0;
    case (sel)
      3'h1:    r = lvl[0];
      3'h2:    r = lvl[1];
      3'h3:    r = lvl[2];
      3'h4:    r = lvl[3];
      3'h5:    r = lvl[0] | lvl[1];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sel_level

endpackage : cutoff_pkg

// *** rtl/req_input_check.sv ***
// one safety request input: glitch filter and test pulse watchdog
// assumes the input is synchronous to clk and low means request
`timescale 1ns/1ps
`default_nettype none
module req_input_check (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  input  wire logic diag_en,
  input  wire logic ms_tick,
  input  wire logic diag_clear,
  output var  logic req,
  output var  logic diag_fail
);

  logic [7:0] low_cnt_reg;
  logic [7:0] gap_ms_reg;
  logic       din_prev_reg;
  wire        fall      = din_prev_reg & ~din;
  wire        low_full  = (low_cnt_reg == cutoff_pkg::FILTER_CYC);
  wire        gap_over  = (gap_ms_reg >= cutoff_pkg::DIAG_TIMEOUT_MS);
  wire  [7:0] low_next  = din ? 8'h00 : (low_full ? low_cnt_reg : low_cnt_reg + 8'h01);

  // short test pulses stay below the filter so they never read as a request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_reg  <= 8'h00;
      din_prev_reg <= 1'b1;
      req          <= 1'b0;
    end else begin
      low_cnt_reg  <= low_next;
      din_prev_reg <= din;
      req          <= (low_next == cutoff_pkg::FILTER_CYC);
    end
  end

  // gap since the last pulse; a held request is not a wiring fault
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_ms_reg <= 8'h00;
      diag_fail  <= 1'b0;
    end else begin
      if (fall || req || !diag_en)
        gap_ms_reg <= 8'h00;
      else if (ms_tick && !gap_over)
        gap_ms_reg <= gap_ms_reg + 8'h01;
      diag_fail <= (diag_en && gap_over) || (diag_fail && !diag_clear);
    end
  end

  a_diag_missing_pulse: assert property (
    @(posedge clk) disable iff (!rst_b)
    diag_en && gap_over |=> diag_fail)
    else $error("missing test pulses not flagged");

endmodule : req_input_check
`default_nettype wire

// *** rtl/torque_cutoff_ack_timer.sv ***
// torque cutoff control: request selection, restart and standstill timers,
// acknowledgement and completion indication, APB register slave
// assumes all inputs synchronous to clk; digital inputs low mean request
`timescale 1ns/1ps
`default_nettype none

module torque_cutoff_ack_timer #(
  parameter int TICK_CYCLES = cutoff_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [3:0]  din,
  input  wire logic        overtemp_req,
  input  wire logic        internal_fault,
  input  wire logic        ramp_force,
  input  wire logic        encoder_fail,
  input  wire logic        zero_speed,
  input  wire logic        modulation_stopped,
  input  wire logic        monitor_unsafe,
  input  wire logic        drive_reset,
  output var  logic        torque_cutoff,
  output var  logic        cutoff_done,
  output var  logic        restart_allowed,
  output var  logic        brake_cmd,
  output var  logic        fault_reset_req,
  output var  logic        monitor_ok,
  output var  logic [1:0]  diag_fail,
  output var  logic        config_err
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  cutoff_pkg::cutoff_state_t state_reg, state_next;
  logic [7:0]  ctrl_reg;
  logic [15:0] sel_reg;
  logic [15:0] restart_reg;
  logic [15:0] stand_reg;
  logic [15:0] prescale_reg;
  logic [15:0] ms_count_reg;
  logic        forced_cause_reg;
  logic        fault_pend_reg;
  logic        unsafe_reg;
  logic        ack_prev_reg;
  logic        mod_prev_reg;
  logic        req_a;
  logic        req_b;

  // configuration fields
  wire        ack_manual = ctrl_reg[cutoff_pkg::CTRL_ACK_MANUAL];
  wire [1:0]  brake_use  = ctrl_reg[cutoff_pkg::CTRL_BRAKE_LSB +: 2];
  wire [1:0]  event_type = ctrl_reg[cutoff_pkg::CTRL_EVENT_LSB +: 2];
  wire        enc_used   = ctrl_reg[cutoff_pkg::CTRL_ENCODER];
  wire [2:0]  prim_sel   = sel_reg[cutoff_pkg::SEL_PRIMARY_LSB +: 3];
  wire [2:0]  sec_sel    = sel_reg[cutoff_pkg::SEL_SECONDARY_LSB +: 3];
  wire [2:0]  ack_sel    = sel_reg[cutoff_pkg::SEL_ACK_LSB +: 3];
  wire [2:0]  ramped_sel = sel_reg[cutoff_pkg::SEL_RAMPED_LSB +: 3];

  // APB decode; one access phase, pready comes from the setup edge
  wire setup    = psel & ~penable;
  wire wr_en    = psel & penable & pready & pwrite;
  wire hit_ctrl = (paddr == cutoff_pkg::OFS_CTRL);
  wire hit_sel  = (paddr == cutoff_pkg::OFS_SEL);
  wire hit_rst  = (paddr == cutoff_pkg::OFS_RESTART);
  wire hit_std  = (paddr == cutoff_pkg::OFS_STAND);
  wire hit_stat = (paddr == cutoff_pkg::OFS_STATUS);
  wire hit_clr  = (paddr == cutoff_pkg::OFS_CLEAR);
  wire hit_any  = hit_ctrl | hit_sel | hit_rst | hit_std | hit_stat | hit_clr;
  wire diag_clr = wr_en & hit_clr & pwdata[0];

  // request levels: filtered channels 1..2, plain channels 3..4
  wire [3:0] req_lvl    = {~din[3], ~din[2], req_b, req_a};
  wire       prim_req   = cutoff_pkg::sel_level(prim_sel, req_lvl);
  wire       sec_req    = cutoff_pkg::sel_level(sec_sel, req_lvl);
  wire       ack_lvl    = cutoff_pkg::sel_level(ack_sel, din);
  wire       ack_edge   = ack_lvl & ~ack_prev_reg;
  // dual pair on primary with any ramped selection would double-book the inputs; stop safe
  wire       cfg_bad    = (prim_sel == cutoff_pkg::SEL_DUAL) &&
                          (ramped_sel != cutoff_pkg::SEL_NONE);
  wire       input_req  = prim_req | sec_req;
  wire       forced_req = overtemp_req | internal_fault | ramp_force |
                          (enc_used & encoder_fail) | cfg_bad;
  wire       any_req    = input_req | forced_req;
  wire       in_run     = (state_reg == cutoff_pkg::ST_RUN);
  wire       mod_rise   = modulation_stopped & ~mod_prev_reg;
  wire       start      = in_run & (any_req | mod_rise);

  // timer comparisons
  wire ms_tick      = (prescale_reg == TICK_LAST);
  wire stand_done   = (ms_count_reg >= stand_reg);
  wire restart_done = (ms_count_reg >= restart_reg);
  // input-only cutoff waits the restart delay, anything forced waits standstill
  wire permit       = forced_cause_reg ? stand_done : restart_done;
  // encoder shows real standstill unless it failed
  wire done_cond    = (enc_used && !encoder_fail) ? zero_speed : stand_done;
  // the same ack method governs every stop function of the module
  wire ack_ok       = ack_manual ? ack_edge : 1'b1;
  wire release_ok   = ~in_run & ~any_req & permit & ack_ok;
  wire fault_set    = in_run & input_req & (event_type == cutoff_pkg::EVENT_FAULT);
  wire fault_next   = fault_set | (fault_pend_reg & ~drive_reset);
  wire forced_next  = in_run ? forced_req : (forced_cause_reg | forced_req);

  // cutoff sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cutoff_pkg::ST_RUN:   if (any_req) state_next = cutoff_pkg::ST_COAST;
      cutoff_pkg::ST_COAST: begin
        if (release_ok)     state_next = cutoff_pkg::ST_RUN;
        else if (done_cond) state_next = cutoff_pkg::ST_STILL;
      end
      cutoff_pkg::ST_STILL: if (release_ok) state_next = cutoff_pkg::ST_RUN;
      default:              state_next = cutoff_pkg::ST_COAST;
    endcase
  end

  // state and cause
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg        <= cutoff_pkg::ST_RUN;
      forced_cause_reg <= 1'b0;
      fault_pend_reg   <= 1'b0;
      ack_prev_reg     <= 1'b0;
      mod_prev_reg     <= 1'b0;
    end else begin
      state_reg        <= state_next;
      forced_cause_reg <= forced_next;
      fault_pend_reg   <= fault_next;
      ack_prev_reg     <= ack_lvl;
      mod_prev_reg     <= modulation_stopped;
    end
  end

  // millisecond timer, restarted with each new cutoff or a modulation stop seen in run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_reg <= 16'h0000;
      ms_count_reg <= 16'h0000;
    end else if (start) begin
      prescale_reg <= 16'h0000;
      ms_count_reg <= 16'h0000;
    end else begin
      prescale_reg <= ms_tick ? 16'h0000 : prescale_reg + 16'h0001;
      if (ms_tick && ms_count_reg != 16'hffff)
        ms_count_reg <= ms_count_reg + 16'h0001;
    end
  end

  // unsafe at the stop is held until the monitor itself recovers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      unsafe_reg <= 1'b0;
    else
      unsafe_reg <= (start & monitor_unsafe) | (unsafe_reg & monitor_unsafe);
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      torque_cutoff   <= 1'b0;
      cutoff_done     <= 1'b0;
      restart_allowed <= 1'b0;
      brake_cmd       <= 1'b0;
      fault_reset_req <= 1'b0;
      monitor_ok      <= 1'b0;
      config_err      <= 1'b0;
    end else begin
      torque_cutoff   <= (state_next != cutoff_pkg::ST_RUN);
      cutoff_done     <= (state_next == cutoff_pkg::ST_STILL);
      restart_allowed <= ~in_run & permit & ~fault_next;
      brake_cmd       <= (brake_use != cutoff_pkg::BRAKE_NONE) &&
                         (state_next != cutoff_pkg::ST_RUN);
      fault_reset_req <= fault_next;
      monitor_ok      <= unsafe_reg & stand_done;
      config_err      <= cfg_bad;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg    <= cutoff_pkg::CTRL_RST;
      sel_reg     <= cutoff_pkg::SEL_RST;
      restart_reg <= cutoff_pkg::RESTART_RST;
      stand_reg   <= cutoff_pkg::STAND_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg    <= pwdata[7:0];
      if (hit_sel)  sel_reg     <= pwdata[15:0];
      if (hit_rst)  restart_reg <= pwdata[15:0];
      if (hit_std)  stand_reg   <= pwdata[15:0];
    end
  end

  // read mux; status shows the live sequence and timer
  wire [31:0] status = {ms_count_reg, 6'h00, monitor_ok, fault_pend_reg, config_err,
                        diag_fail, permit, cutoff_done, forced_cause_reg, state_reg};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_reg} :
                       hit_sel  ? {16'h0000, sel_reg} :
                       hit_rst  ? {16'h0000, restart_reg} :
                       hit_std  ? {16'h0000, stand_reg} :
                       hit_stat ? status : 32'h00000000;

  // answer is sampled at the setup edge, so access is never stretched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
      pready  <= setup;
      pslverr <= setup & ~hit_any;
    end
  end

  // the two pulse-checked request channels
  req_input_check u_chan_a (
    .clk        (clk),
    .rst_b      (rst_b),
    .din        (din[0]),
    .diag_en    (ctrl_reg[cutoff_pkg::CTRL_DIAG1]),
    .ms_tick    (ms_tick),
    .diag_clear (diag_clr),
    .req        (req_a),
    .diag_fail  (diag_fail[0])
  );

  req_input_check u_chan_b (
    .clk        (clk),
    .rst_b      (rst_b),
    .din        (din[1]),
    .diag_en    (ctrl_reg[cutoff_pkg::CTRL_DIAG2]),
    .ms_tick    (ms_tick),
    .diag_clear (diag_clr),
    .req        (req_b),
    .diag_fail  (diag_fail[1])
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_cutoff_begin;
    in_run && any_req;
  endsequence

  sequence s_release;
    !in_run && state_next == cutoff_pkg::ST_RUN;
  endsequence

  a_overtemp_cuts: assert property (
    overtemp_req |=> torque_cutoff)
    else $error("overtemperature did not cut torque");

  a_auto_ack_clear: assert property (
    !ack_manual && !in_run && !any_req && permit |=> !torque_cutoff)
    else $error("automatic ack did not clear cutoff");

  a_manual_ack_edge: assert property (
    s_release and ack_manual |-> ack_lvl && !ack_prev_reg)
    else $error("manual release without ack edge");

  a_restart_delay: assert property (
    s_release and !forced_cause_reg |-> ms_count_reg >= restart_reg)
    else $error("release before restart delay");

  a_forced_standstill: assert property (
    s_release and forced_cause_reg |-> ms_count_reg >= stand_reg)
    else $error("forced release before standstill");

  a_done_standstill: assert property (
    state_reg == cutoff_pkg::ST_COAST && !enc_used && stand_done && !release_ok
    |=> cutoff_done ##0 state_reg == cutoff_pkg::ST_STILL)
    else $error("completion not raised after standstill");

  a_brake_none: assert property (
    brake_use == cutoff_pkg::BRAKE_NONE |=> !brake_cmd)
    else $error("brake driven while usage is none");

  a_fault_reset: assert property (
    fault_reset_req && !drive_reset |=> fault_reset_req && !restart_allowed)
    else $error("fault cleared without drive reset");

  a_timer_restart: assert property (
    s_cutoff_begin |=> ms_count_reg == 16'h0000 ##1 torque_cutoff)
    else $error("timer not restarted at cutoff");

  a_monitor_ok: assert property (
    unsafe_reg && stand_done |=> monitor_ok)
    else $error("monitor ok missing after standstill");

endmodule : torque_cutoff_ack_timer
`default_nettype wire

// *** dv/req_circuit_model.sv ***
// far side model: request contacts with test pulses and ack button
// assumes clk is the block's clock; low on a request line means request
`timescale 1ns/1ps
`default_nettype none
module req_circuit_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       req,
  input  wire logic       req2,
  input  wire logic       ack,
  input  wire logic       pulse_on,
  output wire logic [3:0] din
);
  logic [6:0] cnt_reg;
  // pulse period of 128 cycles stays well inside the 20 ms watchdog
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end
  // two-cycle low pulse is short enough that the input filter ignores it
  wire logic test_pulse = pulse_on && (cnt_reg < 7'h02);
  assign din[0] = !(req || test_pulse);
  assign din[1] = !(req || test_pulse);
  assign din[2] = ack;
  assign din[3] = !req2;
endmodule : req_circuit_model
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench of the torque cutoff timer
// assumes the design's ms tick is shortened to T clocks
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int T = 10;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0]  din;
  logic [2:0]  force_v;
  logic        encoder_fail, zero_speed, modulation_stopped, monitor_unsafe, drive_reset;
  logic        torque_cutoff, cutoff_done, restart_allowed, brake_cmd;
  logic        fault_reset_req, monitor_ok, config_err, req, req2, ack, pulse_on;
  logic [1:0]  diag_fail;
  int          mismatches, n_checks, c, st, rs;

  torque_cutoff_ack_timer #(.TICK_CYCLES(T)) u_dut (
    .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din(din), .overtemp_req(force_v[0]),
    .internal_fault(force_v[1]), .ramp_force(force_v[2]),
    .encoder_fail(encoder_fail), .zero_speed(zero_speed),
    .modulation_stopped(modulation_stopped), .monitor_unsafe(monitor_unsafe),
    .drive_reset(drive_reset), .torque_cutoff(torque_cutoff),
    .cutoff_done(cutoff_done), .restart_allowed(restart_allowed),
    .brake_cmd(brake_cmd), .fault_reset_req(fault_reset_req),
    .monitor_ok(monitor_ok), .diag_fail(diag_fail), .config_err(config_err));

  req_circuit_model u_far (.clk(clk), .rst_b(rst_b), .req(req), .req2(req2),
    .ack(ack), .pulse_on(pulse_on), .din(din));

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic sig(input int w);
    case (w)
      0: return torque_cutoff;
      1: return cutoff_done;
      2: return restart_allowed;
      3: return fault_reset_req;
      4: return config_err;
      6: return monitor_ok;
      default: return &diag_fail;
    endcase
  endfunction : sig

  // bounded wait; values read at the edge are those settled before it
  task automatic wait_sig(input int w, input logic val, input int mx);
    c = 0;
    while (sig(w) !== val && c < mx) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_sig

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // generous bound: the sequence needs well under two thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, force_v} = '0;
    {encoder_fail, zero_speed, modulation_stopped, monitor_unsafe, drive_reset} = '0;
    {req, req2, ack} = '0;
    pulse_on = 1'b1;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(32'hf3a3));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, cutoff_pkg::OFS_CTRL, 0);    chk(rd, 32'h68);
    apb(1'b0, cutoff_pkg::OFS_SEL, 0);     chk(rd, 32'h5);
    apb(1'b0, cutoff_pkg::OFS_RESTART, 0); chk(rd, 32'h7d0);
    apb(1'b0, cutoff_pkg::OFS_STAND, 0);   chk(rd, 32'h7d0);
    apb(1'b0, 8'h18, 0);
    chk({31'h0, er}, 32'h1);
    // random register traffic on the restart timer word
    repeat (6) begin
      v = $urandom & 32'hffff;
      apb(1'b1, cutoff_pkg::OFS_RESTART, v);
      apb(1'b0, cutoff_pkg::OFS_RESTART, 0);
      chk(rd, v);
    end
    st = 4 + $urandom % 4;
    rs = 1 + $urandom % 3;
    apb(1'b1, cutoff_pkg::OFS_STAND, st);
    apb(1'b1, cutoff_pkg::OFS_RESTART, rs);
    // forced causes: overtemperature, internal fault, forced ramped stop
    for (int i = 0; i < 3; i++) begin
      force_v <= 3'h1 << i;
      monitor_unsafe <= 1'b1;
      wait_sig(0, 1'b1, 4);
      chk(32'(c <= 2), 32'h1);
      wait_sig(1, 1'b1, (st + 2) * T);
      chk(32'(c >= (st - 1) * T && c <= st * T + T), 32'h1);
      chk({31'h0, monitor_ok}, 32'h1);
      chk({31'h0, brake_cmd}, 32'h0);
      force_v <= 3'h0;
      monitor_unsafe <= 1'b0;
      wait_sig(0, 1'b0, 4);
      chk(32'(c <= 3), 32'h1);
    end
    // input requests: dual primary, then secondary on the fourth input
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, cutoff_pkg::OFS_SEL, i ? 32'h45 : 32'h5);
      if (i == 1) req2 <= 1'b1;
      else req <= 1'b1;
      wait_sig(0, 1'b1, 100);
      chk(32'(c >= (i ? 0 : 79) && c <= (i ? 3 : 90)), 32'h1);
      wait_sig(2, 1'b1, (rs + 2) * T);
      chk(32'(c >= (rs - 1) * T && c <= rs * T + T), 32'h1);
      chk({31'h0, torque_cutoff}, 32'h1);
      req <= 1'b0;
      req2 <= 1'b0;
      wait_sig(0, 1'b0, 100);
      chk({31'h0, torque_cutoff}, 32'h0);
    end
    // manual ack through the third input; restart equal to standstill
    apb(1'b1, cutoff_pkg::OFS_RESTART, st);
    apb(1'b1, cutoff_pkg::OFS_CTRL, 32'h69);
    apb(1'b1, cutoff_pkg::OFS_SEL, 32'h305);
    force_v <= 3'h1;
    wait_sig(1, 1'b1, (st + 3) * T);
    force_v <= 3'h0;
    repeat (2 * T) @(posedge clk);
    chk({31'h0, torque_cutoff}, 32'h1);
    ack <= 1'b1;
    wait_sig(0, 1'b0, 6);
    chk({31'h0, torque_cutoff}, 32'h0);
    ack <= 1'b0;
    // fault event type needs a drive reset
    apb(1'b1, cutoff_pkg::OFS_CTRL, 32'h78);
    apb(1'b1, cutoff_pkg::OFS_SEL, 32'h5);
    req <= 1'b1;
    wait_sig(3, 1'b1, 100);
    repeat ((st + 1) * T) @(posedge clk);
    chk({31'h0, fault_reset_req, restart_allowed}, 32'h2);
    req <= 1'b0;
    repeat (100) @(posedge clk);
    drive_reset <= 1'b1;
    wait_sig(3, 1'b0, 4);
    chk({31'h0, fault_reset_req}, 32'h0);
    drive_reset <= 1'b0;
    // dual primary together with a ramped primary is a config error
    apb(1'b1, cutoff_pkg::OFS_SEL, 32'h1005);
    wait_sig(4, 1'b1, 4);
    repeat (2) @(posedge clk);
    chk({30'h0, config_err, torque_cutoff}, 32'h3);
    apb(1'b1, cutoff_pkg::OFS_SEL, 32'h5);
    wait_sig(0, 1'b0, (st + 3) * T);
    chk({31'h0, config_err}, 32'h0);
    // encoder in use with brake usage set: failure forces the cutoff
    apb(1'b1, cutoff_pkg::OFS_CTRL, 32'hea);
    encoder_fail <= 1'b1;
    wait_sig(1, 1'b1, (st + 3) * T);
    chk(32'(c >= (st - 1) * T), 32'h1);
    chk({31'h0, brake_cmd}, 32'h1);
    encoder_fail <= 1'b0;
    wait_sig(0, 1'b0, 6);
    chk({31'h0, torque_cutoff}, 32'h0);
    // healthy encoder: completion waits for zero speed, not the time
    force_v <= 3'h1;
    repeat ((st + 2) * T) @(posedge clk);
    chk({31'h0, cutoff_done}, 32'h0);
    zero_speed <= 1'b1;
    wait_sig(1, 1'b1, 4);
    chk(32'(c <= 2), 32'h1);
    {force_v, zero_speed} <= '0;
    wait_sig(0, 1'b0, 6);
    chk({31'h0, torque_cutoff}, 32'h0);
    // modulation lost while unsafe: ok after standstill, no cutoff
    monitor_unsafe <= 1'b1;
    modulation_stopped <= 1'b1;
    wait_sig(6, 1'b1, (st + 2) * T);
    chk(32'(c >= (st - 1) * T && c <= st * T + T), 32'h1);
    chk({31'h0, torque_cutoff}, 32'h0);
    {monitor_unsafe, modulation_stopped} <= '0;
    // missing test pulses raise the sticky diag flags
    chk({30'h0, diag_fail}, 32'h0);
    pulse_on <= 1'b0;
    wait_sig(5, 1'b1, 260);
    chk({30'h0, diag_fail}, 32'h3);
    pulse_on <= 1'b1;
    repeat (140) @(posedge clk);
    apb(1'b1, cutoff_pkg::OFS_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    chk({30'h0, diag_fail}, 32'h0);
    // reset in mid-run while a cutoff is held
    force_v <= 3'h1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, torque_cutoff}, 32'h0);
    force_v <= 3'h0;
    rst_b <= 1'b1;
    apb(1'b0, cutoff_pkg::OFS_CTRL, 0);  chk(rd, 32'h68);
    apb(1'b0, cutoff_pkg::OFS_STAND, 0); chk(rd, 32'h7d0);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
